// [design/ead_corr_calc.sv]
// operand access cycle correction by width, location, alignment
`timescale 1ns/100ps
module ead_corr_calc
	import ead_pkg::*;
(
	input wire logic is_register,
	input ead_width_t width,
	input ead_loc_t loc,
	input wire logic odd_addr,
	output ead_corr_t corr
);
	// access counts when the access is not split
	wire [2:0] plain_acc = (width == EAD_W_LONG) ? 3'd2 : 3'd1;
	// split access counts for misaligned or narrow bus
	wire [2:0] split_acc = (width == EAD_W_LONG) ? 3'd4 :
		(width == EAD_W_WORD) ? 3'd2 : 3'd1;
	// penalty when split, and for even sixteen bit access
	wire [3:0] split_cyc_ext = (width == EAD_W_LONG) ? EAD_CYC_EIGHT :
		(width == EAD_W_WORD) ? EAD_CYC_FOUR : EAD_CYC_ONE;
	wire [3:0] split_cyc_int = (width == EAD_W_LONG) ? EAD_CYC_FOUR :
		(width == EAD_W_WORD) ? EAD_CYC_TWO : EAD_CYC_ZERO;
	wire [3:0] even_ext = (width == EAD_W_LONG) ? EAD_CYC_TWO : EAD_CYC_ONE;

	always_comb begin
		corr.cycles = EAD_CYC_ZERO;
		corr.accesses = plain_acc;
		if (is_register) begin
			corr.cycles = EAD_CYC_ZERO;
		end else if (loc == EAD_LOC_INTERNAL) begin
			if (odd_addr) begin
				corr.cycles = split_cyc_int;
				corr.accesses = split_acc;
			end
		end else if (loc == EAD_LOC_EXT16) begin
			if (odd_addr) begin
				corr.cycles = split_cyc_ext;
				corr.accesses = split_acc;
			end else begin
				corr.cycles = even_ext;
			end
		end else begin
			corr.cycles = split_cyc_ext;
			corr.accesses = split_acc;
		end
	end
endmodule : ead_corr_calc

// [design/ead_decoder.sv]
// effective address decoder with registered timing outputs
`timescale 1ns/100ps
// Contract
// - codes 00-07 select register directly
// - 08-0B indirect, 2 cycles, 1 access
// - 0C-0F post-increment, 4 cycles, 2 accesses
// - 10-17 short displacement, one extension byte
// - 18-1B long displacement, two extension bytes
// - 1C/1D indexed by register seven, 4 cycles
// - 1E pc relative, 1F direct address
// - internal odd word/long add cycles
// - sixteen bit bus penalties by alignment
// - eight bit bus penalties always
// - external accesses add wait cycles
// - fetch penalty per boundary crossed
module ead_decoder
	import ead_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic decode_valid,
	input wire logic [4:0] code,
	input ead_width_t width,
	input ead_loc_t operand_loc,
	input wire logic odd_addr,
	input wire logic [3:0] wait_cycles,
	input ead_loc_t fetch_loc,
	input wire logic [2:0] fetch_units,
	output logic result_valid,
	output ead_mode_t mode,
	output logic [2:0] reg_sel,
	output logic use_index,
	output logic [2:0] index_reg,
	output logic [1:0] ext_bytes,
	output logic ext_bytes_valid,
	output logic [3:0] base_cycles,
	output logic [1:0] base_accesses,
	output logic [3:0] corr_cycles,
	output logic [2:0] corr_accesses,
	output logic [4:0] fetch_cycles,
	output logic [7:0] total_cycles
);
	// decoded mode fields
	ead_decode_t info;
	// operand correction
	ead_corr_t corr;
	// register operand flag
	wire is_register = (code < EAD_CODE_IND_LO);
	// external bus in use
	wire is_external = !is_register && (operand_loc != EAD_LOC_INTERNAL);
	wire [3:0] wait_add = is_external ? wait_cycles : 4'h0;
	// per-unit fetch penalty
	wire [3:0] fetch_unit_cyc = (fetch_loc == EAD_LOC_INTERNAL) ?
		EAD_CYC_TWO : EAD_CYC_THREE;
	wire [6:0] fetch_prod = 7'(fetch_unit_cyc * fetch_units);
	// external fetch also waits
	wire [4:0] fetch_next = (fetch_loc == EAD_LOC_INTERNAL) ?
		fetch_prod[4:0] : 5'(fetch_prod[4:0] + wait_cycles);
	// total of all components
	wire [7:0] total_next = 8'(info.base_cycles + corr.cycles
		+ wait_add + fetch_next);

	// mode table
	ead_mode_rom u_rom (
		.code(code),
		.info(info)
	);

	// operand correction table
	ead_corr_calc u_corr (
		.is_register(is_register),
		.width(width),
		.loc(operand_loc),
		.odd_addr(odd_addr),
		.corr(corr)
	);

	// valid strobe register
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			result_valid <= 1'b0;
			ext_bytes_valid <= 1'b0;
		end else begin
			result_valid <= decode_valid;
			ext_bytes_valid <= decode_valid;
		end
	end

	// result fields other than index_reg captured on each decode
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			mode <= EAD_M_REG;
			reg_sel <= 3'h0;
			use_index <= 1'b0;
			index_reg <= EAD_INDEX_REG;
			ext_bytes <= 2'h0;
			base_cycles <= 4'h0;
			base_accesses <= 2'h0;
			corr_cycles <= 4'h0;
			corr_accesses <= 3'h0;
			fetch_cycles <= 5'h0;
			total_cycles <= 8'h00;
		end else if (decode_valid) begin
			mode <= info.mode;
			reg_sel <= info.reg_sel;
			use_index <= info.use_index;
			ext_bytes <= info.ext_bytes;
			base_cycles <= info.base_cycles;
			base_accesses <= info.base_accesses;
			corr_cycles <= corr.cycles;
			corr_accesses <= corr.accesses;
			fetch_cycles <= fetch_next;
			total_cycles <= total_next;
		end
	end

	reg_direct_a: assert property (@(posedge clock) disable iff (!rst_n)
		decode_valid && code < 5'h08 |=> mode == EAD_M_REG && ext_bytes == 2'h0
		&& reg_sel == $past(code[2:0]))
		else $error("register direct decode wrong");

	ind_count_a: assert property (@(posedge clock) disable iff (!rst_n)
		decode_valid && code >= 5'h08 && code <= 5'h0b |=> base_cycles == 4'h2
		&& base_accesses == 2'h1 && ext_bytes == 2'h0 && mode == EAD_M_IND)
		else $error("indirect counts wrong");

	post_inc_a: assert property (@(posedge clock) disable iff (!rst_n)
		decode_valid && code >= 5'h0c && code <= 5'h0f |=> base_cycles == 4'h4
		&& base_accesses == 2'h2 && reg_sel == {1'b0, $past(code[1:0])})
		else $error("post increment counts wrong");

	disp_short_a: assert property (@(posedge clock) disable iff (!rst_n)
		decode_valid && code[4:3] == 2'b10 |=> ext_bytes == 2'h1
		&& reg_sel == $past(code[2:0]) && base_cycles == 4'h2)
		else $error("short displacement wrong");

	disp_long_a: assert property (@(posedge clock) disable iff (!rst_n)
		decode_valid && code >= 5'h18 && code <= 5'h1b |=> ext_bytes == 2'h2
		&& base_accesses == 2'h1 && reg_sel[2] == 1'b0)
		else $error("long displacement wrong");

	index_mode_a: assert property (@(posedge clock) disable iff (!rst_n)
		decode_valid && (code == 5'h1c || code == 5'h1d) |=> use_index
		&& base_cycles == 4'h4 && reg_sel == {2'b00, $past(code[0])})
		else $error("indexed decode wrong");

	pc_direct_a: assert property (@(posedge clock) disable iff (!rst_n)
		decode_valid && code >= 5'h1e |=> ext_bytes == 2'h2
		&& base_accesses == 2'h0
		&& base_cycles == ($past(code[0]) ? 4'h1 : 4'h2))
		else $error("pc or direct decode wrong");

	// odd word on sixteen bit bus
	ext_odd_a: assert property (@(posedge clock) disable iff (!rst_n)
		decode_valid && code >= 5'h08 && operand_loc == EAD_LOC_EXT16
		&& odd_addr && width == EAD_W_WORD |=> corr_cycles == 4'h4
		&& corr_accesses == 3'h2)
		else $error("odd external word correction wrong");

	ext8_long_a: assert property (@(posedge clock) disable iff (!rst_n)
		decode_valid && code >= 5'h08 && operand_loc == EAD_LOC_EXT8
		&& width == EAD_W_LONG |=> corr_cycles == 4'h8
		&& corr_accesses == 3'h4)
		else $error("eight bit long correction wrong");

	reset_clear_a: assert property (@(posedge clock)
		!rst_n |=> !result_valid && !ext_bytes_valid && ext_bytes == 2'h0
		&& mode == EAD_M_REG && index_reg == EAD_INDEX_REG
		&& total_cycles == 8'h00 && fetch_cycles == 5'h00)
		else $error("reset values wrong");

	valid_rise_a: assert property (@(posedge clock) disable iff (!rst_n)
		decode_valid |=> result_valid && ext_bytes_valid)
		else $error("valid strobe missing");

	valid_fall_a: assert property (@(posedge clock) disable iff (!rst_n)
		!decode_valid |=> !result_valid && !ext_bytes_valid)
		else $error("valid strobe too long");

	field_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
		!decode_valid |=> $stable(mode) && $stable(reg_sel)
		&& $stable(ext_bytes) && $stable(base_cycles)
		&& $stable(corr_cycles) && $stable(total_cycles))
		else $error("fields changed without decode");

	mem_mode_a: assert property (@(posedge clock) disable iff (!rst_n)
		decode_valid && code >= 5'h08 |=> mode != EAD_M_REG)
		else $error("memory code decoded as register");

	low_no_ext_a: assert property (@(posedge clock) disable iff (!rst_n)
		decode_valid && !code[4] |=> ext_bytes == 2'h0)
		else $error("extension bytes for low code");

	// index only for its two codes
	index_only_a: assert property (@(posedge clock) disable iff (!rst_n)
		decode_valid && code != 5'h1c && code != 5'h1d |=> !use_index)
		else $error("index flag on wrong code");

	pc_mode_a: assert property (@(posedge clock) disable iff (!rst_n)
		decode_valid && code >= 5'h1e |=> reg_sel == 3'h0 && mode ==
		($past(code[0]) ? EAD_M_DIRECT : EAD_M_PCREL))
		else $error("pc or direct mode wrong");

	reg_corr_a: assert property (@(posedge clock) disable iff (!rst_n)
		decode_valid && code < 5'h08 |=> corr_cycles == 4'h0
		&& corr_accesses == ($past(width) == EAD_W_LONG ? 3'h2 : 3'h1))
		else $error("register operand correction wrong");

	int_even_a: assert property (@(posedge clock) disable iff (!rst_n)
		decode_valid && code >= 5'h08 && operand_loc == EAD_LOC_INTERNAL
		&& !odd_addr |=> corr_cycles == 4'h0)
		else $error("internal even correction wrong");

	int_odd_word_a: assert property (@(posedge clock) disable iff (!rst_n)
		decode_valid && code >= 5'h08 && operand_loc == EAD_LOC_INTERNAL
		&& odd_addr && width == EAD_W_WORD |=> corr_cycles == 4'h2
		&& corr_accesses == 3'h2)
		else $error("internal odd word correction wrong");

	int_odd_long_a: assert property (@(posedge clock) disable iff (!rst_n)
		decode_valid && code >= 5'h08 && operand_loc == EAD_LOC_INTERNAL
		&& odd_addr && width == EAD_W_LONG |=> corr_cycles == 4'h4
		&& corr_accesses == 3'h4)
		else $error("internal odd long correction wrong");

	ext_even_a: assert property (@(posedge clock) disable iff (!rst_n)
		decode_valid && code >= 5'h08 && operand_loc == EAD_LOC_EXT16
		&& !odd_addr |=> corr_cycles ==
		($past(width) == EAD_W_LONG ? 4'h2 : 4'h1))
		else $error("even external correction wrong");

	// odd long on sixteen bit bus
	ext_odd_long_a: assert property (@(posedge clock) disable iff (!rst_n)
		decode_valid && code >= 5'h08 && operand_loc == EAD_LOC_EXT16
		&& odd_addr && width == EAD_W_LONG |=> corr_cycles == 4'h8
		&& corr_accesses == 3'h4)
		else $error("odd external long correction wrong");

	ext8_word_a: assert property (@(posedge clock) disable iff (!rst_n)
		decode_valid && code >= 5'h08 && operand_loc == EAD_LOC_EXT8
		&& width == EAD_W_WORD |=> corr_cycles == 4'h4
		&& corr_accesses == 3'h2)
		else $error("eight bit word correction wrong");

	ext8_byte_a: assert property (@(posedge clock) disable iff (!rst_n)
		decode_valid && code >= 5'h08 && operand_loc == EAD_LOC_EXT8
		&& width == EAD_W_BYTE |=> corr_cycles == 4'h1
		&& corr_accesses == 3'h1)
		else $error("eight bit byte correction wrong");

	wait_sum_a: assert property (@(posedge clock) disable iff (!rst_n)
		decode_valid && code >= 5'h08 && operand_loc != EAD_LOC_INTERNAL
		&& fetch_loc == EAD_LOC_INTERNAL && fetch_units == 3'h0
		|=> total_cycles == 8'(base_cycles) + 8'(corr_cycles)
		+ 8'($past(wait_cycles)))
		else $error("wait cycles not counted");

	no_wait_a: assert property (@(posedge clock) disable iff (!rst_n)
		decode_valid && (code < 5'h08 || operand_loc == EAD_LOC_INTERNAL)
		&& fetch_loc == EAD_LOC_INTERNAL && fetch_units == 3'h0
		|=> total_cycles == 8'(base_cycles) + 8'(corr_cycles))
		else $error("wait added without external access");

	fetch_int_a: assert property (@(posedge clock) disable iff (!rst_n)
		decode_valid && fetch_loc == EAD_LOC_INTERNAL
		|=> fetch_cycles == 5'($past(fetch_units)) * 5'h02)
		else $error("internal fetch correction wrong");

	fetch_ext_a: assert property (@(posedge clock) disable iff (!rst_n)
		decode_valid && fetch_loc != EAD_LOC_INTERNAL
		|=> fetch_cycles == 5'($past(fetch_units)) * 5'h03
		+ 5'($past(wait_cycles)))
		else $error("external fetch correction wrong");

	reg_total_a: assert property (@(posedge clock) disable iff (!rst_n)
		decode_valid && code < 5'h08 |=> total_cycles == 8'(fetch_cycles))
		else $error("register total wrong");
endmodule : ead_decoder

// [design/ead_mode_rom.sv]
// combinational mode table from effective address code
`timescale 1ns/100ps
module ead_mode_rom
	import ead_pkg::*;
(
	input wire logic [4:0] code,
	output ead_decode_t info
);
	// range decodes
	wire is_reg = (code < EAD_CODE_IND_LO);
	wire is_ind = !is_reg && (code < EAD_CODE_POST_LO);
	wire is_post = (code >= EAD_CODE_POST_LO) && (code < EAD_CODE_D8_LO);
	wire is_d8 = (code >= EAD_CODE_D8_LO) && (code < EAD_CODE_D16_LO);
	wire is_d16 = (code >= EAD_CODE_D16_LO) && (code < EAD_CODE_IDX0);
	wire is_idx = (code == EAD_CODE_IDX0) || (code == EAD_CODE_IDX1);
	wire is_pc = (code == EAD_CODE_PCREL);

	always_comb begin
		info = '0;
		// low-four register fields use code bits 1:0, register and short displacement 2:0
		info.reg_sel = is_d8 || is_reg ? code[2:0] : {1'b0, code[1:0]};
		if (is_reg) begin
			info.mode = EAD_M_REG;
		end else if (is_ind) begin
			info.mode = EAD_M_IND;
			info.base_cycles = EAD_CYC_TWO;
			info.base_accesses = 2'd1;
		end else if (is_post) begin
			info.mode = EAD_M_POSTINC;
			info.base_cycles = EAD_CYC_FOUR;
			info.base_accesses = 2'd2;
		end else if (is_d8) begin
			info.mode = EAD_M_SHORT_DISPLACEMENT;
			info.ext_bytes = 2'd1;
			info.base_cycles = EAD_CYC_TWO;
			info.base_accesses = 2'd1;
		end else if (is_d16) begin
			info.mode = EAD_M_LONG_DISPLACEMENT;
			info.ext_bytes = 2'd2;
			info.base_cycles = EAD_CYC_TWO;
			info.base_accesses = 2'd1;
		end else if (is_idx) begin
			info.mode = EAD_M_INDEX;
			info.reg_sel = {2'b00, code[0]};
			info.use_index = 1'b1;
			info.base_cycles = EAD_CYC_FOUR;
			info.base_accesses = 2'd2;
		end else if (is_pc) begin
			info.mode = EAD_M_PCREL;
			info.reg_sel = 3'h0;
			info.ext_bytes = 2'd2;
			info.base_cycles = EAD_CYC_TWO;
		end else begin
			info.mode = EAD_M_DIRECT;
			info.reg_sel = 3'h0;
			info.ext_bytes = 2'd2;
			info.base_cycles = EAD_CYC_ONE;
		end
	end
endmodule : ead_mode_rom

// [shared/ead_pkg.sv]
// package of constants and carrier types for the effective address decoder
package ead_pkg;
	// effective address code boundaries
	localparam logic [4:0] EAD_CODE_IND_LO = 5'h08;
	localparam logic [4:0] EAD_CODE_POST_LO = 5'h0c;
	localparam logic [4:0] EAD_CODE_D8_LO = 5'h10;
	localparam logic [4:0] EAD_CODE_D16_LO = 5'h18;
	localparam logic [4:0] EAD_CODE_IDX0 = 5'h1c;
	localparam logic [4:0] EAD_CODE_IDX1 = 5'h1d;
	localparam logic [4:0] EAD_CODE_PCREL = 5'h1e;
	localparam logic [4:0] EAD_CODE_DIRECT = 5'h1f;
	// register number used as index
	localparam logic [2:0] EAD_INDEX_REG = 3'h7;
	// base and correction cycle counts
	localparam logic [3:0] EAD_CYC_ONE = 4'h1;
	localparam logic [3:0] EAD_CYC_TWO = 4'h2;
	localparam logic [3:0] EAD_CYC_FOUR = 4'h4;
	localparam logic [3:0] EAD_CYC_THREE = 4'h3;
	localparam logic [3:0] EAD_CYC_EIGHT = 4'h8;
	localparam logic [3:0] EAD_CYC_ZERO = 4'h0;

	// operand width
	typedef enum logic [1:0] {
		EAD_W_BYTE,
		EAD_W_WORD,
		EAD_W_LONG
	} ead_width_t;

	// operand or fetch location
	typedef enum logic [1:0] {
		EAD_LOC_INTERNAL,
		EAD_LOC_EXT16,
		EAD_LOC_EXT8
	} ead_loc_t;

	// addressing mode
	typedef enum logic [3:0] {
		EAD_M_REG,
		EAD_M_IND,
		EAD_M_POSTINC,
		EAD_M_SHORT_DISPLACEMENT,
		EAD_M_LONG_DISPLACEMENT,
		EAD_M_INDEX,
		EAD_M_PCREL,
		EAD_M_DIRECT
	} ead_mode_t;

	// decoded mode information
	typedef struct packed {
		ead_mode_t mode;
		logic [2:0] reg_sel;
		logic use_index;
		logic [1:0] ext_bytes;
		logic [3:0] base_cycles;
		logic [1:0] base_accesses;
	} ead_decode_t;

	// correction result
	typedef struct packed {
		logic [3:0] cycles;
		logic [2:0] accesses;
	} ead_corr_t;
endpackage : ead_pkg

// [testbench/tb.sv]
// self-checking bench for the effective address decoder
`timescale 1ns/100ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
	err_count++; $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module tb;
	import ead_pkg::*;
	logic clock, rst_n, decode_valid, odd_addr; // clock, reset, request
	logic [4:0] code; // effective address field
	logic [3:0] wait_cycles; // ready wait cycles
	logic [2:0] fetch_units; // fetch boundaries
	ead_width_t width; // operand width
	ead_loc_t operand_loc, fetch_loc; // operand and fetch location
	logic result_valid, use_index, ext_bytes_valid; // answer flags
	ead_mode_t mode; // decoded mode
	logic [2:0] reg_sel, index_reg, corr_accesses; // register numbers and correction access count
	logic [1:0] ext_bytes, base_accesses; // extension and base access
	logic [3:0] base_cycles, corr_cycles; // cycle figures
	logic [4:0] fetch_cycles; // fetch correction
	logic [7:0] total_cycles; // whole count
	int err_count = 0; // mismatches seen
	int checks_done = 0; // comparisons made
	int cycle_count = 0; // timeout counter
	ead_decoder i_ead_decoder (.clock(clock), .rst_n(rst_n),
		.decode_valid(decode_valid), .code(code), .width(width),
		.operand_loc(operand_loc), .odd_addr(odd_addr),
		.wait_cycles(wait_cycles), .fetch_loc(fetch_loc),
		.fetch_units(fetch_units), .result_valid(result_valid), .mode(mode),
		.reg_sel(reg_sel), .use_index(use_index), .index_reg(index_reg),
		.ext_bytes(ext_bytes), .ext_bytes_valid(ext_bytes_valid),
		.base_cycles(base_cycles), .base_accesses(base_accesses),
		.corr_cycles(corr_cycles), .corr_accesses(corr_accesses),
		.fetch_cycles(fetch_cycles), .total_cycles(total_cycles));
	// free-running clock, 8 ns period
	always #4 clock = ~clock;
	// print counts and verdict, then stop
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : wrap_up
	// cut a hang short
	always @(posedge clock) begin
		cycle_count++;
		if (cycle_count == 5000) begin
			err_count++;
			wrap_up();
		end
	end
	// one decode request, answer sampled one cycle later
	task automatic dec(input logic [4:0] c, input ead_width_t w,
		input ead_loc_t l, input logic o, input logic [3:0] wt,
		input ead_loc_t fl, input logic [2:0] fu);
		@(posedge clock);
		decode_valid <= 1'b1;
		code <= c;
		width <= w;
		operand_loc <= l;
		odd_addr <= o;
		wait_cycles <= wt;
		fetch_loc <= fl;
		fetch_units <= fu;
		@(posedge clock);
		decode_valid <= 1'b0;
		#1;
	endtask : dec
	// compare the mode fields of the answer
	task automatic chk_mode(input ead_mode_t m, input logic [2:0] rs,
		input logic [1:0] e, input logic [3:0] bc, input logic [1:0] ba);
		`CHK("result_valid", 1'b1, result_valid)
		`CHK("ext_bytes_valid", 1'b1, ext_bytes_valid)
		`CHK("mode", m, mode)
		`CHK("reg_sel", rs, reg_sel)
		`CHK("ext_bytes", e, ext_bytes)
		`CHK("base_cycles", bc, base_cycles)
		`CHK("base_accesses", ba, base_accesses)
	endtask : chk_mode
	// expected correction: cycles in bits 6:3, accesses in bits 2:0
	function automatic logic [6:0] corr_exp(int w, int l, int o);
		if (l == 0 && (o == 0 || w == 0)) return {4'h0, w == 2 ? 3'h2 : 3'h1};
		if (l == 0) return w == 1 ? {4'h2, 3'h2} : {4'h4, 3'h4};
		if (l == 1 && o == 0) return w == 2 ? {4'h2, 3'h2} : {4'h1, 3'h1};
		return w == 0 ? {4'h1, 3'h1} : w == 1 ? {4'h4, 3'h2} : {4'h8, 3'h4};
	endfunction : corr_exp
	// register direct codes, no cycles even on external location
	task automatic t_register();
		for (int i = 0; i < 8; i++) begin
			dec(5'(i), EAD_W_WORD, EAD_LOC_INTERNAL, 1'b0, 4'h0,
				EAD_LOC_INTERNAL, 3'h0);
			chk_mode(EAD_M_REG, 3'(i), 2'h0, 4'h0, 2'h0);
			`CHK("corr_acc", 3'h1, corr_accesses)
		end
		dec(5'h03, EAD_W_LONG, EAD_LOC_EXT16, 1'b1, 4'h5, EAD_LOC_INTERNAL, 3'h0);
		`CHK("corr_acc", 3'h2, corr_accesses)
		`CHK("total", 8'h00, total_cycles)
		$display("test register done");
	endtask : t_register
	// plain indirect and post-increment pointers
	task automatic t_pointer();
		for (int i = 8; i < 16; i++) begin
			dec(5'(i), EAD_W_BYTE, EAD_LOC_INTERNAL, 1'b1, 4'h0,
				EAD_LOC_INTERNAL, 3'h0);
			if (i < 12) chk_mode(EAD_M_IND, 3'(i % 4), 2'h0, 4'h2, 2'h1);
			else chk_mode(EAD_M_POSTINC, 3'(i % 4), 2'h0, 4'h4, 2'h2);
			`CHK("total", 8'(i < 12 ? 2 : 4), total_cycles)
		end
		$display("test pointer done");
	endtask : t_pointer
	// short and long displacement codes
	task automatic t_displace();
		for (int i = 16; i < 28; i++) begin
			dec(5'(i), EAD_W_BYTE, EAD_LOC_INTERNAL, 1'b0, 4'h0,
				EAD_LOC_INTERNAL, 3'h0);
			if (i < 24) chk_mode(EAD_M_SHORT_DISPLACEMENT, 3'(i % 8), 2'h1, 4'h2, 2'h1);
			else chk_mode(EAD_M_LONG_DISPLACEMENT, 3'(i % 4), 2'h2, 4'h2, 2'h1);
		end
		$display("test displace done");
	endtask : t_displace
	// indexed, pc relative and direct codes, then fields hold
	task automatic t_special();
		for (int i = 28; i < 30; i++) begin
			dec(5'(i), EAD_W_BYTE, EAD_LOC_INTERNAL, 1'b0, 4'h0,
				EAD_LOC_INTERNAL, 3'h0);
			chk_mode(EAD_M_INDEX, 3'(i % 2), 2'h0, 4'h4, 2'h2);
			`CHK("use_index", 1'b1, use_index)
			`CHK("index_reg", EAD_INDEX_REG, index_reg)
		end
		dec(5'h1e, EAD_W_BYTE, EAD_LOC_INTERNAL, 1'b0, 4'h0, EAD_LOC_INTERNAL, 3'h0);
		chk_mode(EAD_M_PCREL, 3'h0, 2'h2, 4'h2, 2'h0);
		`CHK("use_index", 1'b0, use_index)
		dec(5'h1f, EAD_W_BYTE, EAD_LOC_INTERNAL, 1'b0, 4'h0, EAD_LOC_INTERNAL, 3'h0);
		chk_mode(EAD_M_DIRECT, 3'h0, 2'h2, 4'h1, 2'h0);
		@(posedge clock);
		#1;
		`CHK("valid_drop", 1'b0, result_valid)
		`CHK("mode_hold", EAD_M_DIRECT, mode)
		$display("test special done");
	endtask : t_special
	// every width, location and alignment through an indirect code
	task automatic t_correct();
		logic [6:0] ex;
		for (int k = 0; k < 18; k++) begin
			ex = corr_exp(k / 6, (k / 2) % 3, k % 2);
			dec(5'h08, ead_width_t'(k / 6), ead_loc_t'((k / 2) % 3), 1'(k % 2),
				4'h3, EAD_LOC_INTERNAL, 3'h0);
			`CHK("corr_cyc", ex[6:3], corr_cycles)
			`CHK("corr_acc", ex[2:0], corr_accesses)
			`CHK("total", 8'(2 + ex[6:3] + ((k / 2) % 3 ? 3 : 0)), total_cycles)
		end
		$display("test correct done");
	endtask : t_correct
	// fetch penalty per boundary on each fetch location
	task automatic t_fetch();
		dec(5'h00, EAD_W_BYTE, EAD_LOC_INTERNAL, 1'b0, 4'h4, EAD_LOC_INTERNAL, 3'h3);
		`CHK("fetch", 5'h06, fetch_cycles)
		dec(5'h00, EAD_W_BYTE, EAD_LOC_INTERNAL, 1'b0, 4'h1, EAD_LOC_EXT16, 3'h2);
		`CHK("fetch", 5'h07, fetch_cycles)
		dec(5'h00, EAD_W_BYTE, EAD_LOC_INTERNAL, 1'b0, 4'h2, EAD_LOC_EXT8, 3'h5);
		`CHK("fetch", 5'h11, fetch_cycles)
		`CHK("total", 8'h11, total_cycles)
		dec(5'h18, EAD_W_WORD, EAD_LOC_EXT16, 1'b1, 4'h1, EAD_LOC_INTERNAL, 3'h2);
		`CHK("total", 8'h0b, total_cycles)
		$display("test fetch done");
	endtask : t_fetch
	// reset, then each scenario in turn
	initial begin
		clock = 1'b0;
		rst_n = 1'b0;
		decode_valid = 1'b0;
		code = 5'h00;
		width = EAD_W_BYTE;
		operand_loc = EAD_LOC_INTERNAL;
		odd_addr = 1'b0;
		wait_cycles = 4'h0;
		fetch_loc = EAD_LOC_INTERNAL;
		fetch_units = 3'h0;
		repeat (4) @(posedge clock);
		rst_n <= 1'b1;
		#1;
		`CHK("rst_valid", 1'b0, result_valid)
		`CHK("rst_mode", EAD_M_REG, mode)
		t_register();
		t_pointer();
		t_displace();
		t_special();
		t_correct();
		t_fetch();
		wrap_up();
	end
endmodule : tb
